// ### hw/scp_pkg.sv
// Purpose: Shared constants and types for the serial counter and port block
// Assumes: 32-bit AXI4-Lite register bus, one aligned word per register
// Notes:   Offsets are byte addresses
package scp_pkg;

    localparam int unsigned CLK_HZ       = 10_000_000;
    localparam int unsigned CYCLE_DIV    = 32;
    localparam logic [4:0]  PHASE_LAST   = 5'(CYCLE_DIV - 1);
    localparam logic [1:0]  NIB_LAST     = 2'h3;

    localparam logic [5:0]  A_FEATURE    = 6'h00;
    localparam logic [5:0]  A_ACC        = 6'h04;
    localparam logic [5:0]  A_CARRY      = 6'h08;
    localparam logic [5:0]  A_CMD        = 6'h0C;
    localparam logic [5:0]  A_SERIAL     = 6'h10;
    localparam logic [5:0]  A_DIGIT      = 6'h14;
    localparam logic [5:0]  A_SEG        = 6'h18;
    localparam logic [5:0]  A_GPORT      = 6'h1C;
    localparam logic [5:0]  A_LPINS      = 6'h20;
    localparam logic [5:0]  A_FIFO       = 6'h24;
    localparam logic [5:0]  A_CAPTURE    = 6'h28;

    localparam int unsigned FS_COUNT     = 0;
    localparam int unsigned FS_UNUSED    = 1;
    localparam int unsigned FS_LDRIVE    = 2;
    localparam int unsigned FS_OUTLVL    = 3;

    localparam int unsigned CMD_SWAP     = 0;
    localparam int unsigned CMD_SEG_MA   = 1;
    localparam int unsigned CMD_READ_L   = 2;

    localparam int unsigned FIFO_VALID_B = 8;

    localparam logic [3:0]  RST_FEATURE  = 4'h0;
    localparam logic [3:0]  RST_NIBBLE   = 4'h0;
    localparam logic [7:0]  RST_BYTE     = 8'h00;
    localparam logic        RST_SKL      = 1'b1;
    localparam logic [3:0]  RST_G_OE     = 4'hF;

    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;

    typedef enum logic [1:0] {
        MODE_SHIFT = 2'b01,
        MODE_COUNT = 2'b10
    } scp_mode_e;

    typedef struct packed {
        logic [4:0]  phase;
        logic [3:0]  feature;
        logic [3:0]  acc;
        logic        carry;
        logic [3:0]  digit;
        logic [7:0]  seg;
        logic [3:0]  gport;
        logic [3:0]  serial_shift_counter;
        logic        clock_gate_latch;
        logic        capture;
        logic [1:0]  nib_cnt;
        logic        si_m;
        logic        si_s;
        logic        si_p;
        logic        so;
        logic        sk;
        logic [7:0]  l_out;
        logic [7:0]  l_oe;
        logic [3:0]  g_out;
        logic [3:0]  g_oe;
        logic        awready;
        logic        wready;
        logic        aw_have;
        logic        w_have;
        logic [5:0]  waddr;
        logic [7:0]  wdata;
        logic        wlane;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } scp_state_s;

endpackage : scp_pkg

// ### hw/scp_top.sv
// Purpose: Serial shift register / event counter with LED and general ports
// Assumes: 10 MHz clk, AXI4-Lite slave, inputs synchronous except serial in
// Notes:   One clock; captured nibbles wait in a small FIFO
// Operation
// [R1] Counter mode decrements on serial falling edge
// [R2] Source holds low pulses two cycles minimum
// [R3] Counter mode clock pin shows gate latch
// [R4] Counter mode serial out shows level bit
// [R5] Shift mode shifts left, input into LSB
// [R6] Shift mode, level set: out is MSB
// [R7] Shift mode, level clear: out stays 0
// [R8] Shift mode clock pin is latch AND cycle clock
// [R9] Swap exchanges acc and register, carry to latch
// [R10] Feature bits loaded only by feature write
// [R11] Feature bit one does nothing
// [R12] Drive bit enables LED port, else high-Z
// [R13] LED pin levels readable into acc, digit
// [R14] Segment latch loads from digit+acc or program
// [R15] Acc supplies and takes four segment bits
// [R16] General port register drives pins continuously
// [R17] Instruction cycle is input clock over 32
// [R18] Reset clears state, clock pin as sync
// [R19] Counter wraps; serial input synchronised first
`timescale 1ns/10ps

module scp_fifo #(
    parameter int unsigned W     = 4,
    parameter int unsigned DEPTH = 4
) (
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int unsigned PW = $clog2(DEPTH) + 1;

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [PW-1:0]           wp;
        logic [PW-1:0]           rp;
    } scp_fifo_s;

    scp_fifo_s q;
    scp_fifo_s d;
    logic      full;
    logic      empty;

    // Extra pointer bit tells full from empty without a counter
    assign empty     = (q.wp == q.rp);
    assign full      = (q.wp[PW-2:0] == q.rp[PW-2:0]) && (q.wp[PW-1] != q.rp[PW-1]);
    assign in_ready  = ~full;
    assign out_valid = ~empty;
    assign out_data  = q.mem[q.rp[PW-2:0]];

    always_comb
    begin
        d = q;
        if (in_valid && !full)
        begin
            d.mem[q.wp[PW-2:0]] = in_data;
            d.wp = q.wp + PW'(1);
        end
        if (out_ready && !empty)
        begin
            d.rp = q.rp + PW'(1);
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end
endmodule : scp_fifo

module scp_top
    import scp_pkg::*;
#(
    parameter int unsigned FIFO_DEPTH = 4
) (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        serial_in,
    output logic             serial_out,
    output logic             clock_out_pin,
    input  wire logic [7:0]  led_in,
    output logic [7:0]       led_out,
    output logic [7:0]       led_oe,
    input  wire logic [3:0]  gp_in,
    output logic [3:0]       gp_out,
    output logic [3:0]       gp_oe
);
    scp_state_s q;
    scp_state_s d;
    logic       fifo_in_valid;
    logic       fifo_in_ready;
    logic [3:0] fifo_in_data;
    logic       fifo_out_valid;
    logic       fifo_out_ready;
    logic [3:0] fifo_out_data;
    logic       ar_take;
    logic [5:0] raddr;

    assign ar_take        = s_axi_arvalid && q.arready;
    assign raddr          = s_axi_araddr[5:0];
    assign fifo_out_ready = ar_take && (raddr == A_FIFO) && (s_axi_araddr[31:6] == '0);

    scp_fifo #(
        .W     (4),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rstn      (rstn),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (fifo_in_data),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    always_comb
    begin
        scp_mode_e  mode;
        logic       tick;
        logic       fall;
        logic       stall;
        logic [3:0] shifted;
        logic       do_wr;
        logic       wr_ok;
        mode          = MODE_SHIFT;
        tick          = 1'b0;
        fall          = 1'b0;
        stall         = 1'b0;
        shifted       = 4'h0;
        do_wr         = 1'b0;
        wr_ok         = 1'b0;
        fifo_in_valid = 1'b0;
        fifo_in_data  = 4'h0;
        d             = q;

        mode = q.feature[FS_COUNT] ? MODE_COUNT : MODE_SHIFT;
        // Bit one is stored but never decoded
        // [R11]
        tick    = (q.phase == PHASE_LAST); // [R17]
        d.phase = q.phase + 5'h1; // [R17]

        // Only si_s reads the first stage
        d.si_m = serial_in; // [R19]
        d.si_s = q.si_m; // [R19]
        d.si_p = q.si_s; // [R19]
        fall   = q.si_p && !q.si_s; // [R19]

        shifted = {q.serial_shift_counter[2:0], q.si_s}; // [R5]
        unique case (mode)
            MODE_COUNT:
            begin
                // Pulses shorter than one clk cycle may be missed
                // [R2]
                if (fall)
                begin
                    d.serial_shift_counter = q.serial_shift_counter - 4'h1; // [R1] [R19]
                end
            end
            MODE_SHIFT:
            begin
                if (tick && q.capture)
                begin
                    fifo_in_valid = (q.nib_cnt == NIB_LAST);
                    fifo_in_data  = shifted;
                    // Holding the shift loses no nibble when software lags
                    stall = fifo_in_valid && !fifo_in_ready;
                end
                if (tick && !stall)
                begin
                    d.serial_shift_counter = shifted; // [R5]
                    if (q.capture)
                    begin
                        d.nib_cnt = q.nib_cnt + 2'h1;
                    end
                end
            end
        endcase

        d.awready = q.awready;
        if (s_axi_awvalid && q.awready)
        begin
            d.aw_have = 1'b1;
            d.waddr   = (s_axi_awaddr[31:6] == '0) ? s_axi_awaddr[5:0] : 6'h3F;
        end
        if (s_axi_wvalid && q.wready)
        begin
            d.w_have = 1'b1;
            d.wdata  = s_axi_wdata[7:0];
            d.wlane  = s_axi_wstrb[0];
        end
        do_wr = q.aw_have && q.w_have && !q.bvalid;
        if (do_wr)
        begin
            d.aw_have = 1'b0;
            d.w_have  = 1'b0;
            d.bvalid  = 1'b1;
            wr_ok     = 1'b1;
            unique case (q.waddr)
                A_FEATURE: d.feature = q.wlane ? q.wdata[3:0] : q.feature; // [R10]
                A_ACC:     d.acc     = q.wlane ? q.wdata[3:0] : q.acc;
                A_CARRY:   d.carry   = q.wlane ? q.wdata[0] : q.carry;
                A_DIGIT:   d.digit   = q.wlane ? q.wdata[3:0] : q.digit;
                A_SEG:     d.seg     = q.wlane ? q.wdata : q.seg; // [R14]
                A_GPORT:   d.gport   = q.wlane ? q.wdata[3:0] : q.gport;
                A_CAPTURE:
                begin
                    if (q.wlane)
                    begin
                        d.capture = q.wdata[0];
                        d.nib_cnt = 2'h0;
                    end
                end
                A_CMD:
                begin
                    if (q.wlane && q.wdata[CMD_SWAP])
                    begin
                        d.acc = q.serial_shift_counter; // [R9]
                        d.serial_shift_counter = q.acc; // [R9]
                        d.clock_gate_latch = q.carry; // [R9]
                    end
                    if (q.wlane && q.wdata[CMD_SEG_MA])
                    begin
                        d.seg = {q.acc, q.digit}; // [R14] [R15]
                    end
                    if (q.wlane && q.wdata[CMD_READ_L])
                    begin
                        d.acc   = led_in[7:4]; // [R13] [R15]
                        d.digit = led_in[3:0]; // [R13]
                    end
                end
                A_LPINS, A_SERIAL, A_FIFO:
                begin
                end
                default:
                begin
                    wr_ok = 1'b0;
                end
            endcase
            d.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
        end
        if (q.bvalid && s_axi_bready)
        begin
            d.bvalid = 1'b0;
        end
        d.awready = !d.aw_have && !d.bvalid;
        d.wready  = !d.w_have && !d.bvalid;

        if (ar_take)
        begin
            d.rvalid = 1'b1;
            d.rresp  = RESP_OKAY;
            d.rdata  = 32'h0000_0000;
            if (s_axi_araddr[31:6] != '0)
            begin
                d.rresp = RESP_SLVERR;
            end
            else
            begin
                unique case (raddr)
                    A_FEATURE: d.rdata[3:0] = q.feature;
                    A_ACC:     d.rdata[3:0] = q.acc;
                    A_CARRY:   d.rdata[0]   = q.carry;
                    A_CMD:     d.rdata      = 32'h0000_0000;
                    A_SERIAL:  d.rdata[4:0] = {q.clock_gate_latch, q.serial_shift_counter};
                    A_DIGIT:   d.rdata[3:0] = q.digit;
                    A_SEG:     d.rdata[7:0] = q.seg;
                    A_GPORT:   d.rdata[7:0] = {gp_in, q.gport};
                    A_LPINS:   d.rdata[7:0] = led_in; // [R13]
                    A_CAPTURE: d.rdata[0]   = q.capture;
                    A_FIFO:
                    begin
                        d.rdata[FIFO_VALID_B] = fifo_out_valid;
                        d.rdata[3:0]          = fifo_out_valid ? fifo_out_data : 4'h0;
                    end
                    default:   d.rresp = RESP_SLVERR;
                endcase
            end
        end
        else if (q.rvalid && s_axi_rready)
        begin
            d.rvalid = 1'b0;
        end
        d.arready = !d.rvalid;

        if (d.feature[FS_COUNT])
        begin
            d.so = d.feature[FS_OUTLVL]; // [R4]
            d.sk = d.clock_gate_latch; // [R3]
        end
        else
        begin
            d.so = d.feature[FS_OUTLVL] ? d.serial_shift_counter[3] : 1'b0; // [R6] [R7]
            d.sk = d.clock_gate_latch && !d.phase[4]; // [R8]
        end
        d.l_out = d.seg; // [R12]
        d.l_oe  = {8{d.feature[FS_LDRIVE]}}; // [R12]
        d.g_out = d.gport; // [R16]
        d.g_oe  = RST_G_OE; // [R16]
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            q         <= '0; // [R18]
            q.feature <= RST_FEATURE; // [R18]
            q.acc     <= RST_NIBBLE; // [R18]
            q.gport   <= RST_NIBBLE; // [R18]
            q.seg     <= RST_BYTE;
            q.clock_gate_latch     <= RST_SKL; // [R18]
            q.g_oe    <= RST_G_OE;
        end
        else
        begin
            q <= d;
        end
    end

    assign s_axi_awready = q.awready;
    assign s_axi_wready  = q.wready;
    assign s_axi_bresp   = q.bresp;
    assign s_axi_bvalid  = q.bvalid;
    assign s_axi_arready = q.arready;
    assign s_axi_rdata   = q.rdata;
    assign s_axi_rresp   = q.rresp;
    assign s_axi_rvalid  = q.rvalid;
    assign serial_out    = q.so;
    assign clock_out_pin = q.sk;
    assign led_out       = q.l_out;
    assign led_oe        = q.l_oe;
    assign gp_out        = q.g_out;
    assign gp_oe         = q.g_oe;
endmodule : scp_top

// ### dv/scp_checker_assertions.sv
// Purpose: Port-level checks on scp_top
// Assumes: One clk domain, rstn async active low
// Notes:   Pin checks skip mode-dependent timing that the ports cannot reveal
`timescale 1ns/10ps
module scp_checker
    import scp_pkg::*;
(
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        clock_out_pin,
    input wire logic [7:0]  led_oe,
    input wire logic [3:0]  gp_oe
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    sequence seq_w_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence seq_b_late;
        !s_axi_bvalid ##1 s_axi_bvalid;
    endsequence
    sequence seq_b_wait;
        s_axi_bvalid && !s_axi_bready;
    endsequence

    chk_b_latency: assert property (seq_w_taken |=> seq_b_late)
        else $error("write response not two edges after handshake");
    chk_b_hold: assert property (seq_b_wait |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before bready");
    chk_b_release: assert property (s_axi_bvalid && s_axi_bready
        |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
        else $error("write channel not reopened after response");
    chk_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("second write accepted while response pending");
    chk_r_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read data not one edge after address");
    chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before rready");
    chk_led_oe_same: assert property (led_oe == 8'h00 || led_oe == 8'hFF)
        else $error("LED drivers not switched together");
    chk_gp_drive: assert property (gp_oe == 4'hF)
        else $error("general port not driven");
    chk_sync_pulse: assert property ($rose(rstn) |-> ##[1:2] clock_out_pin [*8])
        else $error("clock pin not pulsing after reset");
endmodule : scp_checker

bind scp_top scp_checker scp_checker_i (.clk, .rstn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .clock_out_pin, .led_oe, .gp_oe);

// ### dv/scp_serial_partner.sv
// Purpose: Far-side serial part: shift register on the clock pin, pulse source
// Assumes: Data sampled and launched on the falling clock pin
// Notes:   Line idles high, as an input with a pull-up would
`timescale 1ns/10ps
module scp_serial_partner (
    input wire logic clk,
    input wire logic serial_out,
    input wire logic clock_out_pin,
    output logic     serial_in
);
    logic tx[$];
    logic rx[$];

    initial serial_in = 1'b1;

    // Falling edge sits half a cycle from the shift edge, so no race on either pin
    always @(negedge clock_out_pin)
    begin
        rx.push_back(serial_out);
        if (tx.size() > 0)
            serial_in <= tx.pop_front();
    end

    // Each level held two instruction cycles so every pulse counts
    task automatic pulse(input int n);
        serial_in <= 1'b1;
        repeat (64) @(posedge clk);
        repeat (n)
        begin
            serial_in <= 1'b0;
            repeat (64) @(posedge clk);
            serial_in <= 1'b1;
            repeat (64) @(posedge clk);
        end
    endtask : pulse
endmodule : scp_serial_partner

// ### dv/scp_top_bench.sv
// Purpose: Self-checking bench for scp_top
// Assumes: 100 ns clk; AXI master moves right after rising edges
// Notes:   Undriven LED pins show an outside pattern so reads are never stale
`timescale 1ns/10ps
module scp_top_bench
    import scp_pkg::*;
;
    logic        clk, rstn, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, serial_in, serial_out, clock_out_pin;
    logic [31:0] awaddr, wdata, araddr, rdata;
    logic [1:0]  bresp, rresp;
    logic [7:0]  led_in, led_out, led_oe, ext_pat, b8;
    logic [3:0]  gp_in, gp_out, gp_oe, v;
    logic        sent[$];
    int          num_errors, compares, cyc, lazy, k;
    time         t0, t1;

    scp_top #(.FIFO_DEPTH(4)) scp_top_i (.clk, .rstn, .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .serial_in, .serial_out, .clock_out_pin, .led_in,
        .led_out, .led_oe, .gp_in, .gp_out, .gp_oe);
    scp_serial_partner scp_serial_partner_i (.clk, .serial_out, .clock_out_pin, .serial_in);
    assign led_in = (led_oe & led_out) | (~led_oe & ext_pat);
    assign gp_in  = (gp_oe & gp_out) | (~gp_oe & ~gp_out);

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic test_done();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : test_done

    task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_p;
        logic w_p;
        aw_p = 1'b1;
        w_p  = 1'b1;
        @(posedge clk);
        awaddr  <= {26'h0, a};
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        while (aw_p || w_p)
        begin
            @(posedge clk);
            if (aw_p && awready === 1'b1)
            begin
                aw_p = 1'b0;
                awvalid <= 1'b0;
            end
            if (w_p && wready === 1'b1)
            begin
                w_p = 1'b0;
                wvalid <= 1'b0;
            end
        end
        repeat (lazy) @(posedge clk);
        bready <= 1'b1;
        do @(posedge clk); while (bvalid !== 1'b1 || bready !== 1'b1);
        bready <= 1'b0;
        chk("bresp", 32'(er), 32'(bresp));
    endtask : wr

    task automatic rd(input string n, input logic [5:0] a, input logic [31:0] e,
                      input logic [1:0] er);
        @(posedge clk);
        araddr  <= {26'h0, a};
        arvalid <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        repeat (lazy) @(posedge clk);
        rready <= 1'b1;
        do @(posedge clk); while (rvalid !== 1'b1 || rready !== 1'b1);
        rready <= 1'b0;
        chk(n, e, rdata);
        chk("rresp", 32'(er), 32'(rresp));
    endtask : rd

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 6000)
        begin
            num_errors++;
            $display("[FAIL] watchdog expected done seen hang");
            test_done();
        end
    end

    initial
    begin
        {rstn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, wdata, araddr} = '0;
        ext_pat = 8'h00;
        void'($urandom(98527));
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        rd("feature", A_FEATURE, 32'h0, RESP_OKAY);
        rd("acc", A_ACC, 32'h0, RESP_OKAY);
        rd("carry", A_CARRY, 32'h0, RESP_OKAY);
        rd("serial", A_SERIAL, 32'h10, RESP_OKAY);
        rd("unmapped", 6'h2C, 32'h0, RESP_SLVERR);
        wr(6'h2C, 32'h1, RESP_SLVERR);
        // Slow ready on both channels keeps the hold checks exercised
        lazy = 3;
        v = 4'($urandom);
        wr(A_GPORT, 32'(v), RESP_OKAY);
        rd("gport", A_GPORT, 32'({v, v}), RESP_OKAY);
        lazy = 0;
        // LED port: pins into acc and digit, then back out through the latch
        ext_pat <= 8'($urandom);
        @(posedge clk);
        chk("led_oe_off", 32'h0, 32'(led_oe));
        rd("lpins", A_LPINS, 32'(ext_pat), RESP_OKAY);
        wr(A_CMD, 32'h4, RESP_OKAY);
        rd("acc_l", A_ACC, 32'(ext_pat[7:4]), RESP_OKAY);
        rd("digit_l", A_DIGIT, 32'(ext_pat[3:0]), RESP_OKAY);
        wr(A_CMD, 32'h2, RESP_OKAY);
        wr(A_FEATURE, 32'h4, RESP_OKAY);
        repeat (2) @(posedge clk);
        chk("led_out_ma", 32'(ext_pat), 32'(led_out));
        chk("led_oe_on", 32'hFF, 32'(led_oe));
        b8 = 8'($urandom);
        wr(A_SEG, 32'(b8), RESP_OKAY);
        repeat (2) @(posedge clk);
        chk("led_out_rom", 32'(b8), 32'(led_out));
        // Shift mode with serial out enabled
        wr(A_FEATURE, 32'h8, RESP_OKAY);
        @(posedge clock_out_pin);
        t0 = $time;
        @(negedge clock_out_pin);
        t1 = $time;
        @(posedge clock_out_pin);
        chk("clk_high", 32'd16, 32'((t1 - t0) / 100));
        chk("clk_period", 32'd32, 32'(($time - t0) / 100));
        @(posedge clk);
        scp_serial_partner_i.rx.delete();
        for (k = 0; k < 12; k++)
        begin
            sent.push_back(1'($urandom));
            scp_serial_partner_i.tx.push_back(sent[k]);
        end
        wait (scp_serial_partner_i.rx.size() >= 16);
        // Bit launched at one falling edge reaches the pin four cycles later
        for (k = 4; k < 16; k++)
            chk("so_msb", 32'(sent[k - 4]), 32'(scp_serial_partner_i.rx[k]));
        wr(A_FEATURE, 32'h2, RESP_OKAY);
        @(posedge clk);
        scp_serial_partner_i.rx.delete();
        for (k = 0; k < 8; k++)
            scp_serial_partner_i.tx.push_back(1'($urandom));
        wait (scp_serial_partner_i.rx.size() >= 8);
        for (k = 0; k < 8; k++)
            chk("so_off", 32'h0, 32'(scp_serial_partner_i.rx[k]));
        // Capture: four shifts of a steady 1 push one full nibble
        scp_serial_partner_i.tx.push_back(1'b1);
        repeat (64) @(posedge clk);
        wr(A_CAPTURE, 32'h1, RESP_OKAY);
        rd("capture", A_CAPTURE, 32'h1, RESP_OKAY);
        repeat (160) @(posedge clk);
        rd("fifo_nib", A_FIFO, 32'h10F, RESP_OKAY);
        rd("fifo_empty", A_FIFO, 32'h0, RESP_OKAY);
        // Counter mode
        wr(A_FEATURE, 32'h1, RESP_OKAY);
        scp_serial_partner_i.pulse(0);
        wr(A_ACC, 32'h0, RESP_OKAY);
        wr(A_CARRY, 32'h1, RESP_OKAY);
        wr(A_CMD, 32'h1, RESP_OKAY);
        rd("serial_swap", A_SERIAL, 32'h10, RESP_OKAY);
        chk("clk_static", 32'h1, 32'(clock_out_pin));
        chk("so_level", 32'h0, 32'(serial_out));
        scp_serial_partner_i.pulse(3);
        rd("count", A_SERIAL, 32'h1D, RESP_OKAY);
        wr(A_FEATURE, 32'h9, RESP_OKAY);
        repeat (2) @(posedge clk);
        chk("so_level", 32'h1, 32'(serial_out));
        v = 4'($urandom);
        wr(A_ACC, 32'(v), RESP_OKAY);
        wr(A_CARRY, 32'h0, RESP_OKAY);
        wr(A_CMD, 32'h1, RESP_OKAY);
        rd("acc_swap", A_ACC, 32'hD, RESP_OKAY);
        rd("serial_swap", A_SERIAL, 32'(v), RESP_OKAY);
        repeat (2) @(posedge clk);
        chk("clk_static", 32'h0, 32'(clock_out_pin));
        test_done();
    end
endmodule : scp_top_bench
